// File: logic/rcs_pkg.sv
// constants, types and register map of the reset cause logic
package rcs_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_PWR = 8'h00;
	localparam logic [7:0] ADDR_FLAGS = 8'h04;
	localparam logic [7:0] ADDR_CFG = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int PWR_BROWNOUT_BIT = 0;
	localparam int PWR_POWERON_BIT = 1;
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_POWERUP_TIMER_DIS_BIT = 2;
	localparam int CFG_BOR_EN_BIT = 3;
	localparam logic [1:0] PWR_RESET = 2'h0;
	localparam logic [3:0] CFG_RESET = 4'h8;
	localparam logic [6:0] IRQ_EN_RESET = 7'h00;

	// event bits of irq status, enable and clear
	localparam int IRQ_POR = 0;
	localparam int IRQ_BOR = 1;
	localparam int IRQ_PIN = 2;
	localparam int IRQ_WDT_RST = 3;
	localparam int IRQ_WDT_WAKE = 4;
	localparam int IRQ_INT_WAKE = 5;
	localparam int IRQ_SEQ_DONE = 6;
	localparam int IRQ_W = 7;

	// ----------------------------------------------------------------
	// program counter and core status loads (value, mask of loaded bits)
	// ----------------------------------------------------------------
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [12:0] PC_IRQ_VECTOR = 13'h0004;
	localparam logic [7:0] ST_POR_VAL = 8'h18;
	localparam logic [7:0] ST_PIN_RUN_VAL = 8'h00;
	localparam logic [7:0] ST_PIN_RUN_MASK = 8'hE0;
	localparam logic [7:0] ST_PIN_SLP_VAL = 8'h10;
	localparam logic [7:0] ST_RST_MASK = 8'hF8;
	localparam logic [7:0] ST_WDT_RST_VAL = 8'h08;
	localparam logic [7:0] ST_WDT_WAKE_VAL = 8'h00;
	localparam logic [7:0] ST_WAKE_MASK = 8'h18;
	localparam logic [7:0] ST_BOR_VAL = 8'h18;
	localparam logic [7:0] ST_INT_WAKE_VAL = 8'h10;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int US_CYCLES = 1000 / CLK_PERIOD_NS;
	localparam int POWERUP_TIMER_TIME_MS = 72;
	localparam int POWERUP_TIMER_TIME_US = POWERUP_TIMER_TIME_MS * 1000;
	localparam int OST_CYCLES = 1024;
	localparam int CNT_W = 17;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_LOWPOWER = 2'h0,
		MODE_STANDARD = 2'h1,
		MODE_FAST = 2'h2,
		MODE_RC = 2'h3
	} rcs_osc_mode_t;

	typedef enum logic [2:0] {
		S_RUN = 3'b001,
		S_POWERUP_TIMER = 3'b010,
		S_OST = 3'b100
	} rcs_state_t;

	typedef struct packed {
		logic valid;
		logic [12:0] pc;
		logic [7:0] status_val;
		logic [7:0] status_mask;
	} rcs_load_t;

endpackage

// File: logic/rcs_reset_cause.sv
// reset cause flags, start-up time-out sequencer and state loads
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module rcs_reset_cause #(
	parameter int POWERUP_TIMER_US = rcs_pkg::POWERUP_TIMER_TIME_US
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic por_evt,
	input wire logic bor_evt,
	input wire logic pin_evt,
	input wire logic wdt_evt,
	input wire logic irq_wake_evt,
	input wire logic sleeping,
	input wire logic global_irq_enable,
	input wire logic [12:0] cur_pc,
	output rcs_pkg::rcs_load_t load,
	output logic core_reset,
	output logic irq
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// first phase of a time-out sequence
	function automatic rcs_pkg::rcs_state_t seq_start(input logic powerup_timer_on, input logic ost_on);
		if (powerup_timer_on) begin
			return rcs_pkg::S_POWERUP_TIMER;
		end
		return ost_on ? rcs_pkg::S_OST : rcs_pkg::S_RUN;
	endfunction

	// register address decode
	function automatic logic is_mapped(input logic [7:0] a);
		return a == rcs_pkg::ADDR_PWR || a == rcs_pkg::ADDR_FLAGS || a == rcs_pkg::ADDR_CFG ||
			a == rcs_pkg::ADDR_IRQ_STAT || a == rcs_pkg::ADDR_IRQ_EN ||
			a == rcs_pkg::ADDR_IRQ_CLR;
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [1:0] power_status_reg;
	logic [3:0] cfg;
	logic timeout_flag;
	logic powerdown_flag;
	logic [6:0] irq_status;
	logic [6:0] irq_enable;
	rcs_pkg::rcs_state_t st;
	rcs_pkg::rcs_state_t next_st;
	logic ost_pending;
	logic [rcs_pkg::CNT_W-1:0] cnt;
	logic [7:0] us_cnt;
	logic us_tick;
	logic ev_por, ev_bor, ev_pin, ev_wdt, ev_irq, any_evt;
	logic seq_restart;
	logic crystal, powerup_timer_on, bor_en, powerup_timer_done, ost_done;
	logic apb_setup, apb_wr;
	logic [6:0] evt_bits;

	// config fields
	assign crystal = rcs_pkg::rcs_osc_mode_t'(cfg[rcs_pkg::CFG_MODE_LSB +: 2]) != rcs_pkg::MODE_RC;
	assign powerup_timer_on = !cfg[rcs_pkg::CFG_POWERUP_TIMER_DIS_BIT];
	assign bor_en = cfg[rcs_pkg::CFG_BOR_EN_BIT];

	// ----------------------------------------------------------------
	// event priority
	// ----------------------------------------------------------------
	// brownout pulses are dropped while detection is off
	assign ev_por = por_evt;
	assign ev_bor = bor_evt && bor_en && !ev_por;
	assign ev_pin = pin_evt && !ev_por && !ev_bor;
	assign ev_wdt = wdt_evt && !ev_por && !ev_bor && !ev_pin;
	assign ev_irq = irq_wake_evt && sleeping && !ev_por && !ev_bor && !ev_pin && !ev_wdt;
	assign any_evt = ev_por || ev_bor || ev_pin || ev_wdt || ev_irq;

	// events that start a time-out; pin and running watchdog resets leave it running
	assign seq_restart = ev_por || ev_bor || (ev_wdt && sleeping) || ev_irq;

	// ----------------------------------------------------------------
	// time-out sequencer
	// ----------------------------------------------------------------
	// microsecond enable for the power-up timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			us_cnt <= 8'h00;
			us_tick <= 1'b0;
		end else if (seq_restart) begin
			us_cnt <= 8'h00; // whole microseconds counted from the event
			us_tick <= 1'b0;
		end else begin
			us_tick <= us_cnt == 8'(rcs_pkg::US_CYCLES - 2);
			us_cnt <= (us_cnt == 8'(rcs_pkg::US_CYCLES - 1)) ? 8'h00 : us_cnt + 8'h01;
		end
	end

	assign powerup_timer_done = us_tick && cnt == rcs_pkg::CNT_W'(POWERUP_TIMER_US - 1);
	assign ost_done = cnt == rcs_pkg::CNT_W'(rcs_pkg::OST_CYCLES - 1);

	// next phase: events restart, timers advance
	always_comb begin
		next_st = st;
		if (ev_por) begin
			next_st = seq_start(powerup_timer_on, crystal);
		end else if (ev_bor) begin
			next_st = seq_start(powerup_timer_on, 1'b0);
		end else if ((ev_wdt && sleeping) || ev_irq) begin
			next_st = seq_start(1'b0, crystal);
		end else begin
			unique case (st)
				rcs_pkg::S_RUN: next_st = rcs_pkg::S_RUN;
				rcs_pkg::S_POWERUP_TIMER: begin
					if (powerup_timer_done) begin
						next_st = ost_pending ? rcs_pkg::S_OST : rcs_pkg::S_RUN;
					end
				end
				rcs_pkg::S_OST: next_st = ost_done ? rcs_pkg::S_RUN : rcs_pkg::S_OST;
				default: next_st = rcs_pkg::S_RUN;
			endcase
		end
	end

	// phase, its counter and whether the oscillator wait follows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= rcs_pkg::S_RUN;
			cnt <= '0;
			ost_pending <= 1'b0;
			core_reset <= 1'b0;
		end else begin
			st <= next_st;
			core_reset <= next_st != rcs_pkg::S_RUN;
			if (ev_por) begin
				ost_pending <= crystal;
			end else if (ev_bor) begin
				ost_pending <= 1'b0;
			end
			if (next_st != st || seq_restart) begin
				cnt <= '0;
			end else if (st == rcs_pkg::S_OST || (st == rcs_pkg::S_POWERUP_TIMER && us_tick)) begin
				cnt <= cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// cause flags
	// ----------------------------------------------------------------
	// hardware clears win over a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_status_reg <= rcs_pkg::PWR_RESET;
		end else begin
			if (apb_wr && paddr == rcs_pkg::ADDR_PWR) begin
				power_status_reg <= pwdata[1:0];
			end
			if (ev_por) begin
				power_status_reg[rcs_pkg::PWR_POWERON_BIT] <= 1'b0;
			end
			if (ev_bor) begin
				power_status_reg[rcs_pkg::PWR_BROWNOUT_BIT] <= 1'b0;
			end
		end
	end

	// timeout and powerdown flags per event, kept on a pin reset while running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout_flag <= 1'b1;
			powerdown_flag <= 1'b1;
		end else if (ev_por || ev_bor) begin
			timeout_flag <= 1'b1;
			powerdown_flag <= 1'b1;
		end else if ((ev_pin && sleeping) || ev_irq) begin
			timeout_flag <= 1'b1;
			powerdown_flag <= 1'b0;
		end else if (ev_wdt) begin
			timeout_flag <= 1'b0;
			powerdown_flag <= !sleeping;
		end
	end

	// ----------------------------------------------------------------
	// core state load
	// ----------------------------------------------------------------
	// working register is never loaded here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load <= '0;
		end else begin
			load.valid <= any_evt;
			if (ev_por) begin
				load.pc <= rcs_pkg::PC_RESET;
				load.status_val <= rcs_pkg::ST_POR_VAL;
				load.status_mask <= rcs_pkg::ST_RST_MASK;
			end else if (ev_bor) begin
				load.pc <= rcs_pkg::PC_RESET;
				load.status_val <= rcs_pkg::ST_BOR_VAL;
				load.status_mask <= rcs_pkg::ST_RST_MASK;
			end else if (ev_pin) begin
				load.pc <= rcs_pkg::PC_RESET;
				load.status_val <= sleeping ? rcs_pkg::ST_PIN_SLP_VAL : rcs_pkg::ST_PIN_RUN_VAL;
				load.status_mask <= sleeping ? rcs_pkg::ST_RST_MASK : rcs_pkg::ST_PIN_RUN_MASK;
			end else if (ev_wdt) begin
				load.pc <= sleeping ? cur_pc + 13'h0001 : rcs_pkg::PC_RESET;
				load.status_val <= sleeping ? rcs_pkg::ST_WDT_WAKE_VAL : rcs_pkg::ST_WDT_RST_VAL;
				load.status_mask <= sleeping ? rcs_pkg::ST_WAKE_MASK : rcs_pkg::ST_RST_MASK;
			end else if (ev_irq) begin
				load.pc <= global_irq_enable ? rcs_pkg::PC_IRQ_VECTOR : cur_pc + 13'h0001;
				load.status_val <= rcs_pkg::ST_INT_WAKE_VAL;
				load.status_mask <= rcs_pkg::ST_WAKE_MASK;
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	assign evt_bits = {st == rcs_pkg::S_OST && next_st == rcs_pkg::S_RUN ||
		st == rcs_pkg::S_POWERUP_TIMER && next_st == rcs_pkg::S_RUN,
		ev_irq, ev_wdt && sleeping, ev_wdt && !sleeping, ev_pin, ev_bor, ev_por};

	// sticky status, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
			irq_enable <= rcs_pkg::IRQ_EN_RESET;
			irq <= 1'b0;
		end else begin
			if (apb_wr && paddr == rcs_pkg::ADDR_IRQ_EN) begin
				irq_enable <= pwdata[6:0];
			end
			if (apb_wr && paddr == rcs_pkg::ADDR_IRQ_CLR) begin
				irq_status <= (irq_status & ~pwdata[6:0]) | evt_bits;
			end else begin
				irq_status <= irq_status | evt_bits;
			end
			irq <= |(irq_status & irq_enable);
		end
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite && pready;

	// answer prepared in setup, given in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= rcs_pkg::CFG_RESET;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_setup;
			if (apb_wr && paddr == rcs_pkg::ADDR_CFG) begin
				cfg <= pwdata[3:0];
			end
			if (apb_setup) begin
				pslverr <= !is_mapped(paddr);
				prdata <= 32'h0000_0000;
				unique case (paddr)
					rcs_pkg::ADDR_PWR: prdata[1:0] <= power_status_reg;
					rcs_pkg::ADDR_FLAGS: prdata[5:0] <= {st, core_reset, powerdown_flag,
						timeout_flag};
					rcs_pkg::ADDR_CFG: prdata[3:0] <= cfg;
					rcs_pkg::ADDR_IRQ_STAT: prdata[6:0] <= irq_status;
					rcs_pkg::ADDR_IRQ_EN: prdata[6:0] <= irq_enable;
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_por_code;
		por_evt |=> !power_status_reg[1] && timeout_flag && powerdown_flag && load.valid;
	endproperty
	a_por_code: assert property (p_por_code) else $error("power-on code wrong");

	property p_por_to;
		por_evt ##1 !power_status_reg[1] |-> timeout_flag;
	endproperty
	a_por_to: assert property (p_por_to) else $error("timeout cleared on power-on");

	property p_por_pd;
		por_evt |=> powerdown_flag && load.status_val[3];
	endproperty
	a_por_pd: assert property (p_por_pd) else $error("powerdown cleared");

	property p_bor;
		bor_evt && bor_en && !por_evt |=> !power_status_reg[0] &&
			power_status_reg[1] == $past(power_status_reg[1]);
	endproperty
	a_bor: assert property (p_bor) else $error("brownout flag not cleared");

	property p_pin_run;
		ev_pin && !sleeping |=> $stable(timeout_flag) && $stable(powerdown_flag);
	endproperty
	a_pin_run: assert property (p_pin_run) else $error("pin reset changed flags");

	property p_sleep_wake;
		(ev_pin && sleeping) || ev_irq |=> timeout_flag && !powerdown_flag;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep exit code wrong");

	property p_wdt_wake_pc;
		ev_wdt && sleeping |=> load.pc == $past(cur_pc) + 13'h0001 && !timeout_flag;
	endproperty
	a_wdt_wake_pc: assert property (p_wdt_wake_pc) else $error("wake pc wrong");

	property p_vector;
		ev_irq && global_irq_enable |=> load.pc == rcs_pkg::PC_IRQ_VECTOR;
	endproperty
	a_vector: assert property (p_vector) else $error("vector not loaded");

	property p_ost_after;
		st == rcs_pkg::S_POWERUP_TIMER && powerup_timer_done && ost_pending && !any_evt |=>
			st == rcs_pkg::S_OST && core_reset;
	endproperty
	a_ost_after: assert property (p_ost_after) else $error("oscillator wait skipped");

	property p_rc_no_wait;
		por_evt && !powerup_timer_on && !crystal |=> !core_reset [*2];
	endproperty
	a_rc_no_wait: assert property (p_rc_no_wait) else $error("rc start held");

	property p_pwr_read;
		apb_setup && paddr == rcs_pkg::ADDR_PWR |=> prdata[31:2] == 30'h0 && pready;
	endproperty
	a_pwr_read: assert property (p_pwr_read) else $error("upper bits set");

endmodule // rcs_reset_cause

// File: test/rcs_tb.sv
// self-checking testbench of the reset cause logic
`timescale 1ns/1ps
module tb;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int POWERUP_TIMER_US_SIM = 4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [4:0] ev = 5'h00;
	logic sleeping = 1'b0;
	logic irq_enable_in = 1'b0;
	logic [12:0] cur_pc = 13'h0123;
	rcs_pkg::rcs_load_t load;
	logic core_reset;
	logic irq;
	logic [31:0] rdat;
	logic rerr;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;

	rcs_reset_cause #(.POWERUP_TIMER_US(POWERUP_TIMER_US_SIM)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .por_evt(ev[0]), .bor_evt(ev[1]), .pin_evt(ev[2]),
		.wdt_evt(ev[3]), .irq_wake_evt(ev[4]), .sleeping(sleeping),
		.global_irq_enable(irq_enable_in), .cur_pc(cur_pc), .load(load),
		.core_reset(core_reset), .irq(irq));

	// ----------------------------------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------------------------------
	initial begin
		forever #2 pclk = ~pclk;
	end

	// hang guard, far above the expected run length
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			$display("[ERR] %0t run did not finish", $time);
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) chk(32'h0, 32'h1, "no pready");
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat & mask, exp, "register read");
	endtask

	// one-cycle source pulse, then the load is looked at
	task automatic fire(input int i);
		@(posedge pclk);
		ev <= 5'h01 << i;
		@(posedge pclk);
		ev <= 5'h00;
		#1;
	endtask

	task automatic evt(input int i, input logic [12:0] pc, input logic [7:0] v, input logic [7:0] m);
		fire(i);
		chk({31'h0, load.valid}, 32'h1, "load valid");
		chk({19'h0, load.pc}, {19'h0, pc}, "load pc");
		chk({24'h0, load.status_mask}, {24'h0, m}, "status mask");
		chk({24'h0, load.status_val & m}, {24'h0, v}, "status value");
	endtask

	// counts cycles until the core is let go
	task automatic run_wait(input int lo, input int hi);
		int n;
		n = 0;
		while (core_reset === 1'b1 && n < 5000) begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk(32'(n >= lo && n <= hi), 32'h1, "start-up length");
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd(rcs_pkg::ADDR_PWR, 32'hFFFFFFFF, 32'h0);
		chk({31'h0, rerr}, 32'h0, "mapped no error");
		rd(rcs_pkg::ADDR_FLAGS, 32'hFFFFFFFF, 32'h0B);
		rd(rcs_pkg::ADDR_CFG, 32'hFFFFFFFF, 32'h8);
		rd(rcs_pkg::ADDR_IRQ_EN, 32'hFFFFFFFF, 32'h0);
		rd(8'h20, 32'hFFFFFFFF, 32'h0);
		chk({31'h0, rerr}, 32'h1, "unmapped error");
		apb(1'b1, rcs_pkg::ADDR_FLAGS, 32'h0);
		rd(rcs_pkg::ADDR_FLAGS, 32'h3, 32'h3);
		$display("test reset done");
	endtask

	task automatic t_por();
		apb(1'b1, rcs_pkg::ADDR_CFG, 32'h8);
		apb(1'b1, rcs_pkg::ADDR_IRQ_EN, 32'h7F);
		evt(0, 13'h0000, 8'h18, 8'hF8);
		chk({31'h0, core_reset}, 32'h1, "core held");
		rd(rcs_pkg::ADDR_PWR, 32'hFFFFFFFF, 32'h0);
		rd(rcs_pkg::ADDR_FLAGS, 32'h3F, 32'h17);
		run_wait(2018, 2030);
		chk({31'h0, irq}, 32'h1, "irq raised");
		rd(rcs_pkg::ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h41);
		apb(1'b1, rcs_pkg::ADDR_IRQ_CLR, 32'h7F);
		apb(1'b1, rcs_pkg::ADDR_IRQ_EN, 32'h0);
		fire(2);
		@(posedge pclk);
		#1;
		chk({31'h0, irq}, 32'h0, "irq masked");
		$display("test power-on done");
	endtask

	task automatic t_bor();
		apb(1'b1, rcs_pkg::ADDR_PWR, 32'h3);
		rd(rcs_pkg::ADDR_PWR, 32'hFFFFFFFF, 32'h3);
		evt(1, 13'h0000, 8'h18, 8'hF8);
		rd(rcs_pkg::ADDR_PWR, 32'hFFFFFFFF, 32'h2);
		run_wait(995, 1005);
		apb(1'b1, rcs_pkg::ADDR_CFG, 32'h2);
		apb(1'b1, rcs_pkg::ADDR_PWR, 32'h3);
		fire(1);
		chk({31'h0, load.valid}, 32'h0, "brown-out while off");
		rd(rcs_pkg::ADDR_PWR, 32'hFFFFFFFF, 32'h3);
		$display("test brown-out done");
	endtask

	task automatic t_wdt_pin();
		evt(3, 13'h0000, 8'h08, 8'hF8);
		rd(rcs_pkg::ADDR_FLAGS, 32'h3, 32'h2);
		evt(2, 13'h0000, 8'h00, 8'hE0);
		rd(rcs_pkg::ADDR_FLAGS, 32'h3, 32'h2);
		sleeping <= 1'b1;
		evt(2, 13'h0000, 8'h10, 8'hF8);
		rd(rcs_pkg::ADDR_FLAGS, 32'h3, 32'h1);
		rd(rcs_pkg::ADDR_PWR, 32'hFFFFFFFF, 32'h3);
		$display("test watchdog and pin done");
	endtask

	task automatic t_wake();
		evt(3, 13'h0124, 8'h00, 8'h18);
		rd(rcs_pkg::ADDR_FLAGS, 32'h3, 32'h0);
		run_wait(1018, 1030);
		evt(4, 13'h0124, 8'h10, 8'h18);
		rd(rcs_pkg::ADDR_FLAGS, 32'h3, 32'h1);
		run_wait(1018, 1030);
		apb(1'b1, rcs_pkg::ADDR_CFG, 32'h1);
		irq_enable_in <= 1'b1;
		evt(4, 13'h0004, 8'h10, 8'h18);
		run_wait(1018, 1030);
		@(posedge pclk);
		sleeping <= 1'b0;
		fire(4);
		chk({31'h0, load.valid}, 32'h0, "wake while running");
		apb(1'b1, rcs_pkg::ADDR_CFG, 32'hF);
		sleeping <= 1'b1;
		evt(3, 13'h0124, 8'h00, 8'h18);
		chk({31'h0, core_reset}, 32'h0, "rc wake no delay");
		evt(0, 13'h0000, 8'h18, 8'hF8);
		chk({31'h0, core_reset}, 32'h0, "rc no timer no delay");
		rd(rcs_pkg::ADDR_PWR, 32'h2, 32'h0);
		$display("test wake-up done");
	endtask

	// ----------------------------------------------------------------
	// main sequence and verdict
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_por();
		t_bor();
		t_wdt_pin();
		t_wake();
		report_and_stop();
	end
endmodule // tb
